/* tb/rtcsp_master_model.sv */
// bus master model: drives the serial clock and pulls the data line low
`timescale 1ns/100ps
module rtcsp_master_model #(
   parameter int GapCycles = 610
) (
   input wire logic mclk, // system clock
   input wire logic sda, // resolved data line
   output logic scl, // serial clock, high when idle
   output logic drvLow // pulls the data line low
);
   initial begin
      scl = 1'b1;
      drvLow = 1'b0;
   end

   task automatic wait_n(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // long low phase so the slave's late acknowledge lands before the rise
   task automatic bit_cycle(input logic b, output logic s);
      drvLow <= ~b;
      wait_n(4);
      scl <= 1'b1;
      wait_n(2);
      s = sda;
      wait_n(1);
      scl <= 1'b0;
      wait_n(1);
   endtask

   // wait before the rise: the slave may still hold the line after a fall
   task automatic put_start();
      drvLow <= 1'b0;
      wait_n(5);
      scl <= 1'b1;
      wait_n(3);
      drvLow <= 1'b1;
      wait_n(3);
      scl <= 1'b0;
      wait_n(1);
   endtask

   task automatic put_stop();
      drvLow <= 1'b1;
      wait_n(5);
      scl <= 1'b1;
      wait_n(3);
      drvLow <= 1'b0;
      wait_n(GapCycles);
   endtask

   task automatic xfer(input logic [7:0] tx, input logic ackBit,
         output logic [7:0] rx, output logic acked);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(tx[i], s);
         rx[i] = s;
      end
      bit_cycle(ackBit, s);
      acked = ~s;
   endtask
endmodule // rtcsp_master_model

/* tb/rtcsp_slave_port_tb_top.sv */
// self-checking bench of the two-wire slave port
`timescale 1ns/100ps
module rtcsp_slave_port_tb_top;
   import rtcsp_pkg::*;
   localparam int unsigned TO = 2000;
   localparam logic [7:0] AW = {SLAVE_ADDR, 1'b0};
   localparam logic [7:0] AR = {SLAVE_ADDR, 1'b1};
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic sclPin, sdaLine, drvLow, sdaOut, sdaOe, regWrite;
   logic accessActive, autoReleased;
   logic [3:0] regWrAddr;
   logic [7:0] regWrData;
   logic [11:0] wrLog[$];
   int errCount = 0;
   int nTests = 0;
   int cycles = 0;

   always #50 mclk = ~mclk;
   // wired-and of both open-drain parties with the pull-up
   assign sdaLine = (sdaOe ? sdaOut : 1'b1) & ~drvLow;

   rtcsp_slave_port #(.TimeoutCycles(TO)) u_dut (
      .mclk(mclk), .resetn(resetn), .sclPin(sclPin), .sdaPin(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .regWrite(regWrite),
      .regWrAddr(regWrAddr), .regWrData(regWrData),
      .accessActive(accessActive), .autoReleased(autoReleased));

   rtcsp_master_model u_master (
      .mclk(mclk), .sda(sdaLine), .scl(sclPin), .drvLow(drvLow));

   always @(posedge mclk) begin
      if (regWrite === 1'b1) begin
         wrLog.push_back({regWrAddr, regWrData});
      end
   end

   task automatic completeRun();
      if (errCount == 0 && nTests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         errCount++;
         completeRun();
      end
   end

   task automatic chk(input logic [11:0] got, input logic [11:0] exp,
         input string what);
      nTests++;
      if (got !== exp) begin
         errCount++;
         $display("[FAIL] %0t ns %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] b, input logic expAck);
      logic [7:0] r;
      logic a;
      u_master.xfer(b, 1'b1, r, a);
      chk({11'h0, a}, {11'h0, expAck}, "ack");
   endtask

   task automatic rd(input logic [7:0] exp, input logic last);
      logic [7:0] r;
      logic a;
      u_master.xfer(8'hFF, last, r, a);
      chk({4'h0, r}, {4'h0, exp}, "read");
   endtask

   task automatic t_write();
      u_master.put_start();
      wr(AW, 1'b1);
      chk({11'h0, accessActive}, 12'h001, "active");
      wr(8'hE0, 1'b1);
      wr(8'hA1, 1'b1);
      wr(8'hB2, 1'b1);
      wr(8'hC3, 1'b1);
      u_master.put_stop();
      chk({11'h0, accessActive}, 12'h000, "idle");
      chk(12'(wrLog.size()), 12'h003, "writes");
      chk(wrLog[0], 12'hEA1, "wr0");
      chk(wrLog[1], 12'hFB2, "wr1");
      chk(wrLog[2], 12'h0C3, "wr2");
   endtask

   // foreign address, then a nonzero format: nothing may be stored
   task automatic t_refuse();
      u_master.put_start();
      wr(AW ^ 8'h02, 1'b0);
      wr(8'hE0, 1'b0);
      u_master.put_start();
      wr(AW, 1'b1);
      wr(8'h01, 1'b1);
      wr(8'h5A, 1'b1);
      u_master.put_stop();
      chk(12'(wrLog.size()), 12'h003, "stored");
   endtask

   task automatic t_read1();
      u_master.put_start();
      wr(AW, 1'b1);
      wr(8'hE0, 1'b1);
      u_master.put_start();
      wr(AR, 1'b1);
      rd(8'hA1, 1'b0);
      rd(8'hB2, 1'b0);
      rd(8'hC3, 1'b0);
      rd(8'h00, 1'b1);
      u_master.wait_n(8);
      chk({11'h0, sdaOe}, 12'h000, "released");
      u_master.put_stop();
   endtask

   task automatic t_read23();
      u_master.put_start();
      wr(AW, 1'b1);
      wr(8'hE4, 1'b1);
      rd(8'hA1, 1'b0);
      rd(8'hB2, 1'b0);
      rd(8'hC3, 1'b0);
      rd(8'h00, 1'b1);
      u_master.put_stop();
      u_master.put_start();
      wr(AR, 1'b1);
      rd(8'hB2, 1'b0);
      rd(8'hC3, 1'b0);
      rd(8'h00, 1'b1);
      u_master.put_stop();
   endtask

   // stall past the limit with no stop, then try both directions
   task automatic t_timeout();
      u_master.put_start();
      wr(AW, 1'b1);
      u_master.wait_n(TO + 100);
      chk({11'h0, autoReleased}, 12'h001, "locked");
      chk({11'h0, accessActive}, 12'h000, "ended");
      u_master.put_start();
      wr(AW, 1'b1);
      wr(8'h10, 1'b0);
      wr(8'h77, 1'b0);
      u_master.put_start();
      wr(AR, 1'b1);
      rd(8'hFF, 1'b1);
      u_master.put_stop();
      chk({11'h0, autoReleased}, 12'h000, "unlock");
      chk(12'(wrLog.size()), 12'h003, "nostore");
   endtask

   initial begin
      repeat (3) @(posedge mclk);
      chk({10'h0, sdaOe, sdaOut}, 12'h000, "rst oe");
      chk({9'h000, regWrite, accessActive, autoReleased}, 12'h000, "rst");
      resetn <= 1'b1;
      repeat (10) @(posedge mclk);
      t_write();
      t_refuse();
      t_read1();
      t_read23();
      t_timeout();
      completeRun();
   end
endmodule // rtcsp_slave_port_tb_top

/* verilog/rtcsp_bus_if.sv */
// interface: decoded line events from the synchroniser to the core
`timescale 1ns/100ps
interface rtcsp_bus_if;
   logic sclLvl;
   logic sdaLvl;
   logic sclRise;
   logic sclFall;
   logic startDet;
   logic stopDet;
   modport sync (output sclLvl, sdaLvl, sclRise, sclFall, startDet,
      stopDet);
   modport core (input sclLvl, sdaLvl, sclRise, sclFall, startDet,
      stopDet);
endinterface

/* verilog/rtcsp_line_sync.sv */
// module: pin synchroniser with clock edge and start/stop detection
`timescale 1ns/100ps
module rtcsp_line_sync (
   input wire logic mclk, // system clock
   input wire logic resetn, // synchronous reset, active low
   input wire logic sclPin, // serial clock pin level
   input wire logic sdaPin, // serial data pin level
   rtcsp_bus_if.sync bus // decoded events
);
   import rtcsp_pkg::*;

   typedef struct packed {
      logic sclMeta;
      logic sclSync;
      logic sclPrev;
      logic sdaMeta;
      logic sdaSync;
      logic sdaPrev;
   } rtcsp_sync_t;

   rtcsp_sync_t st;
   rtcsp_sync_t next_st;

   always_comb begin
      next_st = st;
      next_st.sclMeta = sclPin;
      next_st.sclSync = st.sclMeta;
      next_st.sclPrev = st.sclSync;
      next_st.sdaMeta = sdaPin;
      next_st.sdaSync = st.sdaMeta;
      next_st.sdaPrev = st.sdaSync;
   end

   // reset to idle-high so release of reset never looks like a start
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         st <= '1;
      end else begin
         st <= next_st;
      end
   end

   assign bus.sclLvl = st.sclSync;
   assign bus.sdaLvl = st.sdaSync;
   assign bus.sclRise = st.sclSync & ~st.sclPrev;
   assign bus.sclFall = ~st.sclSync & st.sclPrev;
   assign bus.startDet = st.sclSync & st.sclPrev & st.sdaPrev &
      ~st.sdaSync; // R1
   assign bus.stopDet = st.sclSync & st.sclPrev & ~st.sdaPrev &
      st.sdaSync; // R2
endmodule // rtcsp_line_sync

/* verilog/rtcsp_pkg.sv */
// package: constants and types of the rtc two-wire slave port
// Behaviour
// [R1] SDA falling while SCL high starts access
// [R2] SDA rising while SCL high ends access
// [R3] SDA changes only while SCL low
// [R4] only the master makes start and stop
// [R5] data moves in eight-bit bytes, unlimited count
// [R6] receiver pulls SDA low for ack
// [R7] receiver releases SDA at ninth clock fall
// [R8] reading master withholds ack after last byte
// [R9] after no-ack device keeps SDA released
// [R10] first byte: 7-bit address then direction
// [R11] device answers only address 0110010
// [R12] repeated start continues access, resends address
// [R13] second write byte holds pointer and format
// [R14] writes need format 0000; third byte stored
// [R15] pointer increments per byte, wraps Fh to 0h
// [R16] stop sets pointer to Fh
// [R17] master reads via repeated start, no stop
// [R18] format 4h turns to reading after pointer
// [R19] direct read starts from current pointer
// [R20] read pointer advances and wraps each byte
// [R21] line outputs are open drain, low only
// [R22] access auto-ends half a second after start
// [R23] after auto-end: no write ack, reads FFh
// [R24] master waits 61 us after stop
// [R25] pointer high nibble, format low nibble
// [R26] no ack on foreign address until start
package rtcsp_pkg;
   localparam logic [6:0] SLAVE_ADDR = 7'h32;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] FMT_WRITE = 4'h0;
   localparam logic [3:0] FMT_READ_NOW = 4'h4;
   localparam logic [3:0] PTR_AFTER_STOP = 4'hF;
   localparam logic [3:0] PTR_RESET = 4'hF;
   localparam logic [7:0] READ_LOCKED = 8'hFF;
   localparam int REG_AW = 4;
   localparam int REG_DW = 8;
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned TIMEOUT_MS = 500;
   // longest wait before forced release, rounded down to whole cycles
   localparam int unsigned TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;

   typedef enum logic [2:0] {
      S_IDLE,
      S_ADDR,
      S_ADDR_ACK,
      S_WR_BYTE,
      S_WR_ACK,
      S_RD_BYTE,
      S_RD_ACK,
      S_IGNORE
   } rtcsp_state_t;
endpackage

/* verilog/rtcsp_reg_mem.sv */
// module: register file behind the pointer, registered read port
`timescale 1ns/100ps
module rtcsp_reg_mem #(
   parameter int AW = 4,
   parameter int DW = 8
) (
   input wire logic mclk, // system clock
   input wire logic resetn, // synchronous reset, active low
   input wire logic wrEn, // write strobe
   input wire logic [AW-1:0] wrAddr, // write address
   input wire logic [DW-1:0] wrData, // write data
   input wire logic [AW-1:0] rdAddr, // read address
   output logic [DW-1:0] rdData // read data, one cycle late
);
   import rtcsp_pkg::*;

   typedef struct packed {
      logic [(1<<AW)-1:0][DW-1:0] mem;
      logic [DW-1:0] rd;
   } rtcsp_mem_t;

   rtcsp_mem_t st;
   rtcsp_mem_t next_st;

   always_comb begin
      next_st = st;
      next_st.rd = st.mem[rdAddr];
      if (wrEn) begin
         next_st.mem[wrAddr] = wrData;
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rdData = st.rd;
endmodule // rtcsp_reg_mem

/* verilog/rtcsp_slave_port.sv */
// module: two-wire slave port of the clock, top level
`timescale 1ns/100ps
module rtcsp_slave_port #(
   parameter int unsigned TimeoutCycles = rtcsp_pkg::TIMEOUT_CYCLES
) (
   input wire logic mclk, // system clock, 10 MHz
   input wire logic resetn, // synchronous reset, active low
   input wire logic sclPin, // serial clock pin
   input wire logic sdaPin, // serial data pin level
   output logic sdaOut, // data pin drive value, always low
   output logic sdaOe, // data pin pull-down enable
   output logic regWrite, // register write pulse
   output logic [rtcsp_pkg::REG_AW-1:0] regWrAddr, // written register
   output logic [rtcsp_pkg::REG_DW-1:0] regWrData, // written value
   output logic accessActive, // access running since first start
   output logic autoReleased // access was forced to end
);
   import rtcsp_pkg::*;

   localparam int TW = $clog2(TimeoutCycles + 1);

   typedef struct packed {
      rtcsp_state_t state;
      logic [3:0] bitCnt;
      logic [7:0] rxShift;
      logic [7:0] txShift;
      logic [REG_AW-1:0] ptr;
      logic [3:0] fmt;
      logic firstData;
      logic goRead;
      logic masterAck;
      logic sdaOe;
      logic active;
      logic timedOut;
      logic [TW-1:0] timer;
      logic wrEn;
      logic [REG_AW-1:0] wrAddr;
      logic [REG_DW-1:0] wrData;
   } rtcsp_core_t;

   rtcsp_core_t st;
   rtcsp_core_t next_st;
   logic [REG_DW-1:0] rdData;
   logic [REG_DW-1:0] txByte;
   logic inByte;
   logic timeUp;

   rtcsp_bus_if bus ();

   rtcsp_line_sync u_sync (
      .mclk(mclk),
      .resetn(resetn),
      .sclPin(sclPin),
      .sdaPin(sdaPin),
      .bus(bus.sync)
   );

   rtcsp_reg_mem #(
      .AW(REG_AW),
      .DW(REG_DW)
   ) u_mem (
      .mclk(mclk),
      .resetn(resetn),
      .wrEn(st.wrEn),
      .wrAddr(st.wrAddr),
      .wrData(st.wrData),
      .rdAddr(st.ptr),
      .rdData(rdData)
   );

   assign inByte = (st.state == S_ADDR) || (st.state == S_WR_BYTE) ||
      (st.state == S_RD_BYTE);
   // at-or-past, so a restart landing on the last cycle cannot skip it
   assign timeUp = st.active && (st.timer >= TW'(TimeoutCycles - 1));
   // a locked port answers every read with all ones
   assign txByte = st.timedOut ? READ_LOCKED : rdData; // R23

   always_comb begin
      next_st = st;
      next_st.wrEn = 1'b0;
      if (st.active) begin
         next_st.timer = st.timer + TW'(1);
      end
      if (bus.stopDet) begin
         next_st.state = S_IDLE; // R2
         next_st.ptr = PTR_AFTER_STOP; // R16
         next_st.sdaOe = 1'b0;
         next_st.active = 1'b0;
         // a timeout in the same cycle as the stop still locks the port
         next_st.timedOut = timeUp; // R23
      end else if (bus.startDet) begin
         next_st.state = S_ADDR; // R1 R12
         next_st.bitCnt = '0;
         next_st.sdaOe = 1'b0;
         // a repeated start keeps the running timer
         if (!st.active) begin
            next_st.active = 1'b1;
            next_st.timer = '0; // R22
         end
      end else if (timeUp) begin
         // behaves like a stop so a hung master cannot hold the bus
         next_st.state = S_IDLE; // R22
         next_st.ptr = PTR_AFTER_STOP;
         next_st.sdaOe = 1'b0;
         next_st.active = 1'b0;
         next_st.timedOut = 1'b1; // R23
      end else begin
         if (bus.sclRise && inByte) begin
            next_st.rxShift = {st.rxShift[6:0], bus.sdaLvl}; // R10
            next_st.bitCnt = st.bitCnt + 4'h1; // R5
         end
         if (bus.sclRise && st.state == S_RD_ACK) begin
            next_st.masterAck = !bus.sdaLvl; // R8
         end
         if (bus.sclFall) begin
            unique case (st.state)
               S_IDLE, S_IGNORE: begin
                  next_st.sdaOe = 1'b0;
               end
               S_ADDR: begin
                  if (st.bitCnt == BYTE_BITS) begin
                     if (st.rxShift[7:1] == SLAVE_ADDR) begin // R11
                        next_st.sdaOe = 1'b1; // R6
                        next_st.state = S_ADDR_ACK;
                        next_st.goRead = st.rxShift[0]; // R10
                        next_st.firstData = 1'b1;
                     end else begin
                        next_st.state = S_IGNORE; // R26
                     end
                  end
               end
               S_WR_BYTE: begin
                  if (st.bitCnt == BYTE_BITS) begin
                     next_st.state = S_WR_ACK;
                     next_st.sdaOe = !st.timedOut; // R6 R23
                     if (st.firstData) begin
                        if (!st.timedOut) begin
                           next_st.ptr = st.rxShift[7:4]; // R13 R25
                           next_st.fmt = st.rxShift[3:0]; // R25
                           next_st.goRead =
                              (st.rxShift[3:0] == FMT_READ_NOW); // R18
                        end
                        next_st.firstData = 1'b0;
                     end else if (st.fmt == FMT_WRITE && !st.timedOut)
                     begin
                        next_st.wrEn = 1'b1; // R14
                        next_st.wrAddr = st.ptr;
                        next_st.wrData = st.rxShift;
                        next_st.ptr = st.ptr + 4'h1; // R15
                     end
                  end
               end
               S_ADDR_ACK, S_WR_ACK: begin
                  next_st.bitCnt = '0;
                  if (st.goRead) begin
                     // becomes transmitter right at the ninth fall
                     next_st.state = S_RD_BYTE; // R7 R18 R19
                     next_st.txShift = txByte;
                     next_st.sdaOe = !txByte[7]; // R21
                  end else begin
                     next_st.state = S_WR_BYTE;
                     next_st.sdaOe = 1'b0; // R7
                  end
               end
               S_RD_BYTE: begin
                  if (st.bitCnt == BYTE_BITS) begin
                     next_st.state = S_RD_ACK;
                     next_st.sdaOe = 1'b0; // R6
                     next_st.ptr = st.ptr + 4'h1; // R20 R15
                  end else begin
                     next_st.txShift = {st.txShift[6:0], 1'b0};
                     next_st.sdaOe = !st.txShift[6]; // R3 R21
                  end
               end
               S_RD_ACK: begin
                  next_st.bitCnt = '0;
                  if (st.masterAck) begin
                     next_st.state = S_RD_BYTE; // R5
                     next_st.txShift = txByte;
                     next_st.sdaOe = !txByte[7];
                  end else begin
                     next_st.state = S_IGNORE; // R9
                     next_st.sdaOe = 1'b0;
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!resetn) begin
         st <= '{state: S_IDLE, ptr: PTR_RESET, default: '0};
      end else begin
         st <= next_st;
      end
   end

   assign sdaOut = 1'b0; // R21
   assign sdaOe = st.sdaOe;
   assign regWrite = st.wrEn;
   assign regWrAddr = st.wrAddr;
   assign regWrData = st.wrData;
   assign accessActive = st.active;
   assign autoReleased = st.timedOut;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   a_start_enters_addr: // R1
      assert property (bus.startDet && !bus.stopDet |=>
         st.state == S_ADDR && !sdaOe && st.bitCnt == 4'h0)
      else $error("start did not open address phase");

   a_stop_sets_ptr: // R16
      assert property (bus.stopDet |=>
         st.ptr == PTR_AFTER_STOP && st.state == S_IDLE && !sdaOe)
      else $error("stop did not reset pointer");

   a_foreign_addr_quiet: // R26
      assert property (st.state == S_ADDR && bus.sclFall &&
         st.bitCnt == BYTE_BITS && st.rxShift[7:1] != SLAVE_ADDR &&
         !bus.startDet && !bus.stopDet && !timeUp
         |=> st.state == S_IGNORE && !sdaOe)
      else $error("foreign address was acknowledged");

   a_own_addr_acked: // R11
      assert property (st.state == S_ADDR && bus.sclFall &&
         st.bitCnt == BYTE_BITS && st.rxShift[7:1] == SLAVE_ADDR &&
         !bus.startDet && !bus.stopDet && !timeUp
         |=> sdaOe ##1 sdaOe)
      else $error("own address not acknowledged");

   a_sda_moves_scl_low: // R3
      assert property ($changed(sdaOe) && !$past(bus.stopDet) &&
         !$past(timeUp) |-> !bus.sclLvl)
      else $error("data line moved while clock high");

   a_nack_releases: // R9
      assert property (st.state == S_RD_ACK && bus.sclFall &&
         !st.masterAck && !bus.startDet && !bus.stopDet && !timeUp
         |=> (!sdaOe && st.state == S_IGNORE) [*4])
      else $error("data line held after withheld ack");

   a_read_ptr_step: // R20
      assert property (st.state == S_RD_BYTE && bus.sclFall &&
         st.bitCnt == BYTE_BITS && !bus.startDet && !bus.stopDet &&
         !timeUp |=> st.ptr == $past(st.ptr) + 4'h1)
      else $error("read pointer did not advance");

   a_write_format_gate: // R14
      assert property (regWrite |-> st.fmt == FMT_WRITE &&
         !st.timedOut && st.ptr == regWrAddr + 4'h1)
      else $error("write stored with wrong format or pointer");

   a_timeout_release: // R22
      assert property (timeUp && !bus.startDet && !bus.stopDet |=>
         st.state == S_IDLE && autoReleased && !accessActive &&
         st.ptr == PTR_AFTER_STOP)
      else $error("access not released after timeout");

   a_locked_reads_ones: // R23
      assert property (st.timedOut && $rose(st.state == S_RD_BYTE) |->
         st.txShift == READ_LOCKED)
      else $error("locked read returned data");

   a_fmt4_turnaround: // R18
      assert property (st.state == S_WR_ACK && bus.sclFall && st.goRead &&
         !bus.startDet && !bus.stopDet && !timeUp
         |=> st.state == S_RD_BYTE)
      else $error("format 4h did not turn to reading");

   a_drive_low_only: // R21
      assert property (sdaOut == 1'b0 && (!sdaOe ||
         st.state inside {S_ADDR_ACK, S_WR_ACK, S_RD_BYTE}))
      else $error("data line driven high or out of turn");

   a_tx_bit_drive: // R21
      assert property (st.state == S_RD_BYTE |-> sdaOe == !st.txShift[7])
      else $error("read bit not driven as stored");

   a_locked_write_nack: // R23
      assert property (st.state == S_WR_BYTE && bus.sclFall &&
         st.bitCnt == BYTE_BITS && st.timedOut && !bus.startDet &&
         !bus.stopDet && !timeUp |=> !sdaOe && !regWrite)
      else $error("locked port acknowledged or stored a write");

   a_ack_then_release: // R7
      assert property ((st.state == S_ADDR_ACK || st.state == S_WR_ACK) &&
         bus.sclFall && !st.goRead && !bus.startDet && !bus.stopDet &&
         !timeUp |=> !sdaOe && st.state == S_WR_BYTE && st.bitCnt == 4'h0)
      else $error("acknowledge not released at ninth fall");

   a_restart_keeps_active: // R12
      assert property (accessActive && bus.startDet && !bus.stopDet |=>
         accessActive && st.timer == $past(st.timer) + TW'(1))
      else $error("repeated start restarted the access");

   a_bit_count_step: // R5
      assert property (inByte && bus.sclRise && !bus.startDet &&
         !bus.stopDet && !timeUp |=> st.bitCnt == $past(st.bitCnt) + 4'h1)
      else $error("bit counter did not step on clock rise");

   c_write_stored: cover property (regWrite);
   c_read_byte_done: cover property (st.state == S_RD_ACK && bus.sclFall);
   c_repeated_start: cover property (accessActive && bus.startDet);
   c_auto_release: cover property (timeUp);
   c_format_read: cover property (st.state == S_WR_ACK && st.goRead);
endmodule // rtcsp_slave_port
